/* spc_serial_port_control.sv */
// Purpose: serial port control, status, data buffers and shift engines
// Assumes: register port with read data one cycle after the read strobe
// Notes: mode 0 drives the shift clock on txd and data on the two-way rxd pin
// Summary of operation
// - Control bit 7 is mode bit 0 or the framing error flag, chosen by a power control bit.
// - The framing error flag is set by a bad stop bit and cleared only by software.
// - In modes 2 and 3 with filtering on, a frame whose ninth bit is 0 raises no receive flag.
// - In mode 1 with filtering on, a frame without a valid stop bit raises no receive flag.
// - In mode 0 the filter bit picks the shift rate, clock over 12 or clock over 4.
// - Reception runs only while the receive enable bit is 1.
// - In modes 2 and 3 the software ninth transmit bit is sent as the ninth data bit.
// - In modes 2 and 3 the received ninth bit is stored in the ninth receive field when the receive flag is set.
// - In mode 1 with filtering off the ninth receive field takes the stop bit; mode 0 leaves it.
// - The transmit flag is set after the eighth bit in mode 0 or at stop bit start otherwise.
// - The receive flag is set after the eighth bit in mode 0 or at mid stop bit otherwise.
// - Hardware never clears the receive flag; software does.
// - Control bit 6 is mode bit 1 and with mode bit 0 selects one of four modes.
// - Mode 0 is 8-bit synchronous, mode 1 10-bit, modes 2 and 3 11-bit asynchronous.
// - The data buffer is two registers: reads give received data, writes load transmit data.
module spc_serial_port_control import spc_pkg::*; (
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire logic [7:0] addr_in,
	input wire logic [7:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [7:0] rdata_out,
	input wire logic rxd_in,
	output logic rxd_out,
	output logic rxd_oe_out,
	output logic txd_out,
	output logic irq_out
);
	spc_rate_if rif();
	spc_mode_t mode;
	logic sm0_q, sm1_q, mp_q, ren_q, tb8_q, rb8_q, ti_q, ri_q, fe_q, fesel_q, dbl_q;
	logic sm0_d, sm1_d, mp_d, ren_d, tb8_d, rb8_d, ti_d, ri_d, fe_d, fesel_d, dbl_d;
	logic [7:0] baud_q, baud_d, rbuf_q, rbuf_d, rdata_q, rdata_d;
	logic [SPC_IRQ_W-1:0] stat_q, stat_d, mask_q, mask_d;
	logic irq_q, irq_d;
	spc_tx_t tx_state_q, tx_state_d;
	logic [10:0] tx_sh_q, tx_sh_d;
	logic [3:0] tx_cnt_q, tx_cnt_d, tx_ph_q, tx_ph_d, tx_last;
	logic tx_line_q, tx_line_d, rxd_o_q, rxd_o_d, rxd_oe_q, rxd_oe_d, tx_set_ti;
	spc_rx_t rx_state_q, rx_state_d;
	logic [8:0] rx_sh_q, rx_sh_d;
	logic [3:0] rx_cnt_q, rx_cnt_d, rx_ph_q, rx_ph_d, rx_nbits;
	logic rx_prev_q, rx_set_ri, rx_rb8_we, rx_rb8_val, rx_fe_set, rx_ninth;
	logic [7:0] rx_data;
	logic sclk_q, sclk_d, sclk_rise, txd_q, txd_d;
	logic sc_wr, tx_go, mode_async;

	assign mode = spc_mode_t'({sm0_q, sm1_q});
	assign mode_async = (mode != SPC_MODE0);
	assign sc_wr = wr_in && (addr_in == SPC_SERIAL_CTRL_REG_ADDR);
	assign tx_go = wr_in && (addr_in == SPC_SERIAL_DATA_BUFFER_ADDR);
	assign rif.mode = mode;
	assign rif.mp_sel = mp_q;
	assign rif.rate_dbl = dbl_q;
	assign rif.baud_div = baud_q;
	assign rif.run0 = (tx_state_q == SPC_TX_SYNC) || (rx_state_q == SPC_RX_SYNC);
	assign sclk_rise = rif.half0 && !sclk_q;

	spc_baud u_baud (
		.clk_in(clk_in),
		.rst_b_in(rst_b_in),
		.rif(rif)
	);

	// Transmit engine; frame is start, data LSB first, optional ninth bit, stop
	always_comb begin
		tx_state_d = tx_state_q;
		tx_sh_d = tx_sh_q;
		tx_cnt_d = tx_cnt_q;
		tx_ph_d = tx_ph_q;
		tx_line_d = tx_line_q;
		rxd_o_d = rxd_o_q;
		rxd_oe_d = rxd_oe_q;
		tx_set_ti = 1'h0;
		tx_last = (mode == SPC_MODE1) ? SPC_M1_LAST : SPC_M23_LAST;
		case (tx_state_q)
			SPC_TX_IDLE: begin
				tx_line_d = 1'h1;
				rxd_oe_d = 1'h0;
				if (tx_go && !mode_async) begin
					// Mode 0 receive owns the pins; a write during it is dropped
					if (rx_state_q != SPC_RX_SYNC) begin
						tx_state_d = SPC_TX_SYNC;
						tx_sh_d = {3'h7, wdata_in};
						tx_cnt_d = 4'h0;
						rxd_oe_d = 1'h1;
						rxd_o_d = wdata_in[0];
					end
				end else if (tx_go) begin
					tx_state_d = SPC_TX_ASYNC;
					tx_sh_d = {1'h1, (mode == SPC_MODE1) ? 1'h1 : tb8_q, wdata_in, 1'h0};
					tx_cnt_d = 4'h0;
					tx_ph_d = 4'h0;
					tx_line_d = 1'h0;
				end
			end
			SPC_TX_SYNC: begin
				if (sclk_rise) begin
					if (tx_cnt_q == SPC_M0_LAST_BIT) begin
						tx_set_ti = 1'h1;
						tx_state_d = SPC_TX_IDLE;
						rxd_oe_d = 1'h0;
					end else begin
						tx_sh_d = {1'h1, tx_sh_q[10:1]};
						tx_cnt_d = tx_cnt_q + 4'h1;
						rxd_o_d = tx_sh_q[1];
					end
				end
			end
			SPC_TX_ASYNC: begin
				if (rif.tick16 && tx_ph_q == SPC_OVS_LAST) begin
					tx_ph_d = 4'h0;
					if (tx_cnt_q == tx_last) begin
						tx_state_d = SPC_TX_IDLE;
						tx_line_d = 1'h1;
					end else begin
						tx_cnt_d = tx_cnt_q + 4'h1;
						tx_sh_d = {1'h1, tx_sh_q[10:1]};
						tx_line_d = tx_sh_q[1];
						tx_set_ti = (tx_cnt_q + 4'h1 == tx_last);
					end
				end else if (rif.tick16) begin
					tx_ph_d = tx_ph_q + 4'h1;
				end
			end
			default: tx_state_d = SPC_TX_IDLE;
		endcase
	end

	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			tx_state_q <= SPC_TX_IDLE;
			tx_sh_q <= 11'h7FF;
			tx_cnt_q <= 4'h0;
			tx_ph_q <= 4'h0;
			tx_line_q <= 1'h1;
			rxd_o_q <= 1'h1;
			rxd_oe_q <= 1'h0;
		end else begin
			tx_state_q <= tx_state_d;
			tx_sh_q <= tx_sh_d;
			tx_cnt_q <= tx_cnt_d;
			tx_ph_q <= tx_ph_d;
			tx_line_q <= tx_line_d;
			rxd_o_q <= rxd_o_d;
			rxd_oe_q <= rxd_oe_d;
		end
	end

	// Receive engine; stop bit judged at its middle
	always_comb begin
		rx_state_d = rx_state_q;
		rx_sh_d = rx_sh_q;
		rx_cnt_d = rx_cnt_q;
		rx_ph_d = rx_ph_q;
		rx_set_ri = 1'h0;
		rx_rb8_we = 1'h0;
		rx_rb8_val = 1'h0;
		rx_fe_set = 1'h0;
		rx_nbits = (mode == SPC_MODE1) ? SPC_M1_DBITS : SPC_M23_DBITS;
		rx_ninth = rx_sh_q[8];
		rx_data = (mode == SPC_MODE1) ? rx_sh_q[8:1] : rx_sh_q[7:0];
		case (rx_state_q)
			SPC_RX_IDLE: begin
				// Mode 0 reception waits for the flag to be cleared first
				if (ren_q && !mode_async) begin
					if (!ri_q && tx_state_q == SPC_TX_IDLE && !tx_go) begin
						rx_state_d = SPC_RX_SYNC;
						rx_cnt_d = 4'h0;
					end
				end else if (ren_q && rx_prev_q && !rxd_in) begin
					rx_state_d = SPC_RX_START;
					rx_ph_d = 4'h0;
				end
			end
			SPC_RX_SYNC: begin
				rx_data = {rxd_in, rx_sh_q[8:2]};
				if (!ren_q) begin
					rx_state_d = SPC_RX_IDLE;
				end else if (sclk_rise) begin
					rx_sh_d = {rxd_in, rx_sh_q[8:1]};
					rx_cnt_d = rx_cnt_q + 4'h1;
					if (rx_cnt_q == SPC_M0_LAST_BIT) begin
						rx_set_ri = 1'h1;
						rx_state_d = SPC_RX_IDLE;
					end
				end
			end
			SPC_RX_START: begin
				if (!ren_q) begin
					rx_state_d = SPC_RX_IDLE;
				end else if (rif.tick16 && rx_ph_q == SPC_OVS_MID) begin
					// A start bit gone high by mid bit is a glitch
					rx_state_d = rxd_in ? SPC_RX_IDLE : SPC_RX_DATA;
					rx_ph_d = 4'h0;
					rx_cnt_d = 4'h0;
				end else if (rif.tick16) begin
					rx_ph_d = rx_ph_q + 4'h1;
				end
			end
			SPC_RX_DATA: begin
				if (!ren_q) begin
					rx_state_d = SPC_RX_IDLE;
				end else if (rif.tick16 && rx_ph_q == SPC_OVS_LAST) begin
					rx_ph_d = 4'h0;
					if (rx_cnt_q != rx_nbits) begin
						rx_sh_d = {rxd_in, rx_sh_q[8:1]};
						rx_cnt_d = rx_cnt_q + 4'h1;
					end else begin
						rx_state_d = SPC_RX_IDLE;
						rx_fe_set = !rxd_in;
						if (mode == SPC_MODE1) begin
							rx_set_ri = !mp_q || rxd_in;
							rx_rb8_we = !mp_q;
							rx_rb8_val = rxd_in;
						end else begin
							rx_set_ri = !mp_q || rx_ninth;
							rx_rb8_we = rx_set_ri;
							rx_rb8_val = rx_ninth;
						end
					end
				end else if (rif.tick16) begin
					rx_ph_d = rx_ph_q + 4'h1;
				end
			end
			default: rx_state_d = SPC_RX_IDLE;
		endcase
	end

	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			rx_state_q <= SPC_RX_IDLE;
			rx_sh_q <= 9'h000;
			rx_cnt_q <= 4'h0;
			rx_ph_q <= 4'h0;
			rx_prev_q <= 1'h1;
		end else begin
			rx_state_q <= rx_state_d;
			rx_sh_q <= rx_sh_d;
			rx_cnt_q <= rx_cnt_d;
			rx_ph_q <= rx_ph_d;
			rx_prev_q <= rxd_in;
		end
	end

	// Pins: shift clock idles high and replaces the line in mode 0
	always_comb begin
		sclk_d = rif.run0 ? (sclk_q ^ rif.half0) : 1'h1;
		txd_d = mode_async ? tx_line_d : sclk_d;
	end

	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			sclk_q <= 1'h1;
			txd_q <= 1'h1;
		end else begin
			sclk_q <= sclk_d;
			txd_q <= txd_d;
		end
	end

	// Registers and flags; a hardware set beats a same-cycle software clear
	always_comb begin
		{sm0_d, sm1_d, mp_d, ren_d, tb8_d, rb8_d, ti_d, ri_d} =
			{sm0_q, sm1_q, mp_q, ren_q, tb8_q, rb8_q, ti_q, ri_q};
		{fe_d, fesel_d, dbl_d, baud_d, mask_d, rbuf_d} =
			{fe_q, fesel_q, dbl_q, baud_q, mask_q, rbuf_q};
		stat_d = stat_q;
		if (sc_wr) begin
			if (fesel_q) begin
				fe_d = wdata_in[SPC_B_MODE_LO];
			end else begin
				sm0_d = wdata_in[SPC_B_MODE_LO];
			end
			sm1_d = wdata_in[SPC_B_MODE_HI];
			mp_d = wdata_in[SPC_B_MP];
			ren_d = wdata_in[SPC_B_REN];
			tb8_d = wdata_in[SPC_B_TB8];
			rb8_d = wdata_in[SPC_B_RB8];
			ti_d = wdata_in[SPC_B_TI];
			ri_d = wdata_in[SPC_B_RI];
		end else if (wr_in && addr_in == SPC_PCTRL_ADDR) begin
			fesel_d = wdata_in[SPC_B_FESEL];
			dbl_d = wdata_in[SPC_B_DBL];
		end else if (wr_in && addr_in == SPC_BAUD_ADDR) begin
			baud_d = wdata_in;
		end else if (wr_in && addr_in == SPC_MASK_ADDR) begin
			mask_d = wdata_in[SPC_IRQ_W-1:0];
		end else if (wr_in && addr_in == SPC_STAT_ADDR) begin
			stat_d = stat_q & ~wdata_in[SPC_IRQ_W-1:0];
		end
		if (tx_set_ti) begin
			ti_d = 1'h1;
			stat_d[SPC_I_TX] = 1'h1;
		end
		if (rx_set_ri) begin
			ri_d = 1'h1;
			rbuf_d = rx_data;
			stat_d[SPC_I_RX] = 1'h1;
		end
		if (rx_rb8_we) begin
			rb8_d = rx_rb8_val;
		end
		if (rx_fe_set && fesel_q) begin
			fe_d = 1'h1;
			stat_d[SPC_I_FE] = 1'h1;
		end
		irq_d = |(stat_d & mask_d);
	end

	// Read port; data stand for one cycle only, unmapped reads give zero
	always_comb begin
		rdata_d = 8'h00;
		if (rd_in && addr_in == SPC_SERIAL_CTRL_REG_ADDR) begin
			rdata_d = {fesel_q ? fe_q : sm0_q, sm1_q, mp_q, ren_q, tb8_q, rb8_q, ti_q, ri_q};
		end else if (rd_in && addr_in == SPC_SERIAL_DATA_BUFFER_ADDR) begin
			rdata_d = rbuf_q;
		end else if (rd_in && addr_in == SPC_PCTRL_ADDR) begin
			rdata_d = {dbl_q, fesel_q, 6'h00};
		end else if (rd_in && addr_in == SPC_BAUD_ADDR) begin
			rdata_d = baud_q;
		end else if (rd_in && addr_in == SPC_STAT_ADDR) begin
			rdata_d = {5'h00, stat_q};
		end else if (rd_in && addr_in == SPC_MASK_ADDR) begin
			rdata_d = {5'h00, mask_q};
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			{sm0_q, sm1_q, mp_q, ren_q, tb8_q, rb8_q, ti_q, ri_q} <= 8'h00;
			{fe_q, fesel_q, dbl_q} <= 3'h0;
			baud_q <= SPC_BAUD_RST;
			rbuf_q <= 8'h00;
			stat_q <= SPC_IRQ_RST;
			mask_q <= SPC_IRQ_RST;
			irq_q <= 1'h0;
			rdata_q <= 8'h00;
		end else begin
			{sm0_q, sm1_q, mp_q, ren_q, tb8_q, rb8_q, ti_q, ri_q} <=
				{sm0_d, sm1_d, mp_d, ren_d, tb8_d, rb8_d, ti_d, ri_d};
			{fe_q, fesel_q, dbl_q} <= {fe_d, fesel_d, dbl_d};
			baud_q <= baud_d;
			rbuf_q <= rbuf_d;
			stat_q <= stat_d;
			mask_q <= mask_d;
			irq_q <= irq_d;
			rdata_q <= rdata_d;
		end
	end

	assign rdata_out = rdata_q;
	assign rxd_out = rxd_o_q;
	assign rxd_oe_out = rxd_oe_q;
	assign txd_out = txd_q;
	assign irq_out = irq_q;

	// Checks on the engines and flags
	default clocking spc_cb @(posedge clk_in); endclocking
	default disable iff (!rst_b_in);
	fe_sticky_a: assert property (fe_q && fesel_q && !sc_wr |=> fe_q)
		else $error("framing error flag lost without a write");
	ri_sticky_a: assert property (ri_q && !sc_wr |=> ri_q)
		else $error("receive flag cleared by hardware");
	mp_ninth_a: assert property (rx_state_q == SPC_RX_DATA && mode_async && mode != SPC_MODE1
		&& mp_q && rx_cnt_q == rx_nbits && rif.tick16 && rx_ph_q == SPC_OVS_LAST
		&& !rx_ninth && !ri_q && !sc_wr |=> !ri_q)
		else $error("receive flag raised for ninth bit zero");
	mp_stop_a: assert property (mode == SPC_MODE1 && mp_q && rx_state_q == SPC_RX_DATA
		&& rx_cnt_q == rx_nbits && rif.tick16 && rx_ph_q == SPC_OVS_LAST && !rxd_in
		&& !ri_q && !sc_wr |=> !ri_q)
		else $error("receive flag raised with bad stop bit");
	m0_fast_a: assert property (rif.half0 && sclk_q && mp_q && tx_state_q == SPC_TX_SYNC
		|=> !rif.half0 ##1 rif.half0)
		else $error("fast mode 0 half bit not two clocks");
	m0_slow_a: assert property (rif.half0 && sclk_q && !mp_q && tx_state_q == SPC_TX_SYNC
		|=> !rif.half0 [*5] ##1 rif.half0)
		else $error("slow mode 0 half bit not six clocks");
	ren_off_a: assert property (!ren_q |=> rx_state_q == SPC_RX_IDLE)
		else $error("receiver active while disabled");
	ti_stop_a: assert property (tx_set_ti && mode_async |=> ti_q && tx_line_q
		##1 tx_state_q == SPC_TX_ASYNC)
		else $error("transmit flag not at stop bit start");
	tx_start_a: assert property (tx_go && tx_state_q == SPC_TX_IDLE && mode_async
		|=> tx_state_q == SPC_TX_ASYNC && !txd_q)
		else $error("transmit write did not start a frame");
	rbuf_load_a: assert property (rx_set_ri |=> ri_q && rbuf_q == $past(rx_data))
		else $error("receive buffer not loaded with flag");
	ninth_store_a: assert property (rx_rb8_we && mode_async && mode != SPC_MODE1
		|=> rb8_q == $past(rx_ninth))
		else $error("ninth receive bit not stored");
	tx_frame_c: cover property (tx_set_ti && mode == SPC_MODE3);
	rx_accept_c: cover property (rx_set_ri && mode == SPC_MODE1);
	fe_set_c: cover property (rx_fe_set && fesel_q);
	m0_rx_c: cover property (rx_set_ri && mode == SPC_MODE0);
endmodule

/* spc_pkg.sv */
// Purpose: shared constants and types of the serial port control block
// Assumes: 8-bit register port, 16x oversampling for the asynchronous modes
// Notes: offsets, bit positions, reset values and divider counts live here only
package spc_pkg;
	// Register offsets
	localparam logic [7:0] SPC_SERIAL_CTRL_REG_ADDR = 8'h98;
	localparam logic [7:0] SPC_SERIAL_DATA_BUFFER_ADDR = 8'h99;
	localparam logic [7:0] SPC_PCTRL_ADDR = 8'h9A;
	localparam logic [7:0] SPC_BAUD_ADDR = 8'h9B;
	localparam logic [7:0] SPC_STAT_ADDR = 8'h9C;
	localparam logic [7:0] SPC_MASK_ADDR = 8'h9D;
	// Serial control register bit positions
	localparam int unsigned SPC_B_MODE_LO = 7;
	localparam int unsigned SPC_B_MODE_HI = 6;
	localparam int unsigned SPC_B_MP = 5;
	localparam int unsigned SPC_B_REN = 4;
	localparam int unsigned SPC_B_TB8 = 3;
	localparam int unsigned SPC_B_RB8 = 2;
	localparam int unsigned SPC_B_TI = 1;
	localparam int unsigned SPC_B_RI = 0;
	// Power control register bit positions
	localparam int unsigned SPC_B_DBL = 7;
	localparam int unsigned SPC_B_FESEL = 6;
	// Interrupt status and mask layout
	localparam int unsigned SPC_IRQ_W = 3;
	localparam int unsigned SPC_I_TX = 0;
	localparam int unsigned SPC_I_RX = 1;
	localparam int unsigned SPC_I_FE = 2;
	// Reset values
	localparam logic [7:0] SPC_BAUD_RST = 8'h00;
	localparam logic [SPC_IRQ_W-1:0] SPC_IRQ_RST = 3'h0;
	// Frame timing in oversample ticks and bit indices
	localparam logic [3:0] SPC_OVS_LAST = 4'hF;
	localparam logic [3:0] SPC_OVS_MID = 4'h7;
	localparam logic [3:0] SPC_M0_LAST_BIT = 4'h7;
	localparam logic [3:0] SPC_M1_LAST = 4'h9;
	localparam logic [3:0] SPC_M23_LAST = 4'hA;
	localparam logic [3:0] SPC_M1_DBITS = 4'h8;
	localparam logic [3:0] SPC_M23_DBITS = 4'h9;
	// Mode 0 half bit in clocks: divide by 12 or by 4
	localparam logic [3:0] SPC_M0_HALF_SLOW = 4'h6;
	localparam logic [3:0] SPC_M0_HALF_FAST = 4'h2;
	// Mode 2 clocks per oversample tick: bit at clock/64 or clock/32
	localparam logic [7:0] SPC_M2_TICK_NORM = 8'h04;
	localparam logic [7:0] SPC_M2_TICK_DBL = 8'h02;
	typedef enum logic [1:0] {
		SPC_MODE0 = 2'h0,
		SPC_MODE1 = 2'h1,
		SPC_MODE2 = 2'h2,
		SPC_MODE3 = 2'h3
	} spc_mode_t;
	typedef enum logic [2:0] {
		SPC_TX_IDLE = 3'h1,
		SPC_TX_SYNC = 3'h2,
		SPC_TX_ASYNC = 3'h4
	} spc_tx_t;
	typedef enum logic [3:0] {
		SPC_RX_IDLE = 4'h1,
		SPC_RX_SYNC = 4'h2,
		SPC_RX_START = 4'h4,
		SPC_RX_DATA = 4'h8
	} spc_rx_t;
endpackage

/* spc_rate_if.sv */
// Purpose: carries rate settings to the divider and its tick pulses back
// Assumes: single clock domain
// Notes: ticks are one-cycle enables, never clocks
interface spc_rate_if;
	import spc_pkg::*;
	spc_mode_t mode;
	logic mp_sel;
	logic rate_dbl;
	logic [7:0] baud_div;
	logic run0;
	logic tick16;
	logic half0;
	modport src (input mode, input mp_sel, input rate_dbl, input baud_div, input run0,
		output tick16, output half0);
	modport use_rate (output mode, output mp_sel, output rate_dbl, output baud_div,
		output run0, input tick16, input half0);
endinterface

/* spc_baud.sv */
// Purpose: rate dividers for the serial port
// Assumes: clk_in is the oscillator clock
// Notes: tick16 is the 16x oversample enable, half0 the mode 0 half-bit enable
module spc_baud import spc_pkg::*; (
	input wire logic clk_in,
	input wire logic rst_b_in,
	spc_rate_if.src rif
);
	logic [7:0] ovs_q;
	logic [7:0] ovs_d;
	logic [7:0] ovs_reload;
	logic [3:0] m0_q;
	logic [3:0] m0_d;
	logic [3:0] m0_half;

	// Fixed rate in mode 2, software divisor otherwise
	always_comb begin
		if (rif.mode == SPC_MODE2) begin
			ovs_reload = (rif.rate_dbl ? SPC_M2_TICK_DBL : SPC_M2_TICK_NORM) - 8'h01;
		end else begin
			ovs_reload = rif.baud_div;
		end
		ovs_d = (ovs_q == 8'h00) ? ovs_reload : ovs_q - 8'h01;
		m0_half = rif.mp_sel ? SPC_M0_HALF_FAST : SPC_M0_HALF_SLOW;
		// Phase restarts while idle so the first edge is a full half bit away
		if (!rif.run0 || m0_q == 4'h0) begin
			m0_d = m0_half - 4'h1;
		end else begin
			m0_d = m0_q - 4'h1;
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			ovs_q <= 8'h00;
			m0_q <= SPC_M0_HALF_SLOW - 4'h1;
		end else begin
			ovs_q <= ovs_d;
			m0_q <= m0_d;
		end
	end

	assign rif.tick16 = (ovs_q == 8'h00);
	assign rif.half0 = rif.run0 && (m0_q == 4'h0);
endmodule

/* spc_remote.sv */
// Purpose: remote serial station on the async transmit and receive lines
// Assumes: line idles high; bit time in clocks is given with each call
// Notes: frames are start, data LSB first, stop; no timing checks here
module spc_remote (
	input wire logic clk_in,
	input wire logic txd_in,
	output logic rxd_out
);
	timeunit 1ns;
	timeprecision 100ps;
	initial rxd_out = 1'b1;
	// Send one frame; stop level is free so bad stops can be made
	task automatic send(input logic [8:0] d, input int nd, input logic stp, input int bt);
		@(posedge clk_in);
		rxd_out <= 1'b0;
		repeat (bt) @(posedge clk_in);
		for (int i = 0; i < nd; i++) begin
			rxd_out <= d[i];
			repeat (bt) @(posedge clk_in);
		end
		rxd_out <= stp;
		repeat (bt) @(posedge clk_in);
		rxd_out <= 1'b1;
	endtask
	// Shift mode: bit i is put out at the i-th falling shift clock, so it is steady at the rise
	task automatic shift0(input logic [7:0] d);
		for (int i = 0; i < 8; i++) begin
			@(negedge txd_in);
			rxd_out <= d[i];
		end
		@(posedge txd_in);
		rxd_out <= 1'b1;
	endtask
	// Catch one frame, sampling each bit at its middle
	task automatic grab(input int nd, input int bt, output logic [8:0] d, output logic stp);
		int n;
		n = 0;
		d = 9'h000;
		#1;
		while (txd_in !== 1'b0 && n < 400) begin
			@(posedge clk_in) #1;
			n++;
		end
		repeat (bt / 2) @(posedge clk_in);
		for (int i = 0; i < nd; i++) begin
			repeat (bt) @(posedge clk_in);
			#1 d[i] = txd_in;
		end
		repeat (bt) @(posedge clk_in);
		#1 stp = txd_in;
	endtask
endmodule

/* spc_serial_port_control_tb.sv */
// Purpose: self-checking bench of the serial port control block
// Assumes: baud divisor mostly 0, so a variable-rate bit is 16 clocks
// Notes: mode 2 runs at clock/64, so its bit is 64 clocks
module spc_serial_port_control_tb import spc_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk_in, rst_b_in, wr, rd, rxd_o, rxd_oe, txd, irq, rem_rxd, gs;
	logic [7:0] addr, wdata, rdata, v, rbuf_exp;
	logic [8:0] gd;
	int error_cnt = 0;
	int num_checks = 0;
	int cyc_cnt = 0;
	// Shared data pin: the block wins only while it enables its driver
	wire rxd_w = rxd_oe ? rxd_o : rem_rxd;
	spc_serial_port_control u_spc_serial_port_control (.clk_in(clk_in), .rst_b_in(rst_b_in),
		.addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
		.rxd_in(rxd_w), .rxd_out(rxd_o), .rxd_oe_out(rxd_oe), .txd_out(txd), .irq_out(irq));
	spc_remote u_spc_remote (.clk_in(clk_in), .txd_in(txd), .rxd_out(rem_rxd));
	// 40 MHz oscillator
	initial begin
		clk_in = 1'b0;
		forever #12.5 clk_in = ~clk_in;
	end
	// Hang guard; the whole run needs well under 8000 cycles
	always @(posedge clk_in) begin
		cyc_cnt <= cyc_cnt + 1;
		if (cyc_cnt == 20000) begin
			error_cnt++;
			end_of_test();
		end
	end
	task automatic end_of_test();
		if (error_cnt == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// One-cycle strobes, changed just after the edge
	task automatic wreg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_in);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk_in);
		wr <= 1'b0;
	endtask
	// Read data stands only in the cycle after the strobe
	task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk_in);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_in);
		rd <= 1'b0;
		#1 v = rdata;
		chk(v, exp);
	endtask
	// Interrupt output is registered, so give it two edges to settle
	task automatic irqchk(input logic exp);
		repeat (2) @(posedge clk_in);
		#1 chk({7'h00, irq}, {7'h00, exp});
	endtask
	task automatic t_reset();
		rchk(SPC_SERIAL_CTRL_REG_ADDR, 8'h00);
		rchk(SPC_BAUD_ADDR, SPC_BAUD_RST);
		rchk(SPC_MASK_ADDR, {5'h00, SPC_IRQ_RST});
		wreg(8'h55, 8'hFF);
		rchk(8'h55, 8'h00);
		rchk(SPC_SERIAL_CTRL_REG_ADDR, 8'h00);
		irqchk(1'b0);
	endtask
	// Send one frame and judge what the remote station saw
	task automatic t_tx(input logic [7:0] c, input logic [7:0] d, input int nd, input int bt);
		wreg(SPC_SERIAL_CTRL_REG_ADDR, c);
		wreg(SPC_SERIAL_DATA_BUFFER_ADDR, d);
		u_spc_remote.grab(nd, bt, gd, gs);
		chk(gd[7:0], d);
		chk({7'h00, gd[8]}, (nd == 9) ? {7'h00, c[SPC_B_TB8]} : 8'h00);
		chk({7'h00, gs}, 8'h01);
		rchk(SPC_SERIAL_CTRL_REG_ADDR, c | 8'h02);
		rchk(SPC_SERIAL_DATA_BUFFER_ADDR, rbuf_exp);
		repeat (bt) @(posedge clk_in);
	endtask
	// Receive one frame; rbuf may move only when the flag rises
	task automatic t_rx(input logic [7:0] c, input logic [8:0] d, input int nd, input logic stp,
		input logic [7:0] exp);
		wreg(SPC_SERIAL_CTRL_REG_ADDR, c);
		u_spc_remote.send(d, nd, stp, 16);
		repeat (2) @(posedge clk_in);
		rchk(SPC_SERIAL_CTRL_REG_ADDR, exp);
		if (exp[SPC_B_RI])
			rbuf_exp = d[7:0];
		rchk(SPC_SERIAL_DATA_BUFFER_ADDR, rbuf_exp);
	endtask
	// Shift mode reception: remote drives data, block clocks it in
	task automatic t_m0rx(input logic [7:0] d);
		wreg(SPC_SERIAL_CTRL_REG_ADDR, 8'h10);
		u_spc_remote.shift0(d);
		repeat (8) @(posedge clk_in);
		rchk(SPC_SERIAL_CTRL_REG_ADDR, 8'h11);
		rchk(SPC_SERIAL_DATA_BUFFER_ADDR, d);
		wreg(SPC_SERIAL_CTRL_REG_ADDR, 8'h00);
	endtask
	// Bad stop bit with the error flag selected, then status and interrupt
	task automatic t_fe();
		wreg(SPC_STAT_ADDR, 8'h07);
		wreg(SPC_SERIAL_CTRL_REG_ADDR, 8'h50);
		wreg(SPC_PCTRL_ADDR, 8'h40);
		u_spc_remote.send(9'h066, 8, 1'b0, 16);
		rbuf_exp = 8'h66;
		repeat (2) @(posedge clk_in);
		rchk(SPC_SERIAL_CTRL_REG_ADDR, 8'hD1);
		rchk(SPC_STAT_ADDR, 8'h06);
		irqchk(1'b0);
		wreg(SPC_MASK_ADDR, 8'h02);
		irqchk(1'b1);
		wreg(SPC_STAT_ADDR, 8'h02);
		irqchk(1'b0);
		rchk(SPC_SERIAL_CTRL_REG_ADDR, 8'hD1);
		rchk(SPC_SERIAL_DATA_BUFFER_ADDR, rbuf_exp);
		wreg(SPC_SERIAL_CTRL_REG_ADDR, 8'h50);
		rchk(SPC_SERIAL_CTRL_REG_ADDR, 8'h50);
		wreg(SPC_PCTRL_ADDR, 8'h00);
		wreg(SPC_MASK_ADDR, 8'h00);
		rchk(SPC_SERIAL_CTRL_REG_ADDR, 8'h50);
	endtask
	// Shift mode: measure the low half of the first shift clock, sample data at falls
	task automatic t_m0(input logic [7:0] c, input int h, input logic [7:0] d);
		int n;
		logic [7:0] b;
		n = 0;
		b = 8'h00;
		wreg(SPC_STAT_ADDR, 8'h07);
		wreg(SPC_SERIAL_CTRL_REG_ADDR, c);
		wreg(SPC_SERIAL_DATA_BUFFER_ADDR, d);
		#1 chk({7'h00, rxd_oe}, 8'h01);
		while (txd === 1'b1 && n < 40) begin
			@(posedge clk_in) #1;
			n++;
		end
		// Data only moves on the rise, so the fall sees it steady
		b[0] = rxd_w;
		n = 0;
		while (txd === 1'b0 && n < 40) begin
			@(posedge clk_in) #1;
			n++;
		end
		chk(8'(n), 8'(h));
		for (int i = 1; i < 8; i++) begin
			@(negedge txd);
			#1 b[i] = rxd_w;
		end
		chk(b, d);
		repeat (h + 4) @(posedge clk_in);
		rchk(SPC_SERIAL_CTRL_REG_ADDR, c | 8'h02);
		rchk(SPC_STAT_ADDR, 8'h01);
		chk({7'h00, rxd_oe}, 8'h00);
	endtask
	// Main sequence
	initial begin
		addr = 8'h00;
		wdata = 8'h00;
		wr = 1'b0;
		rd = 1'b0;
		rst_b_in = 1'b0;
		rbuf_exp = 8'h00;
		repeat (10) @(posedge clk_in);
		rst_b_in <= 1'b1;
		t_reset();
		t_tx(8'h40, 8'hA5, 8, 16);
		t_tx(8'hC0, 8'h3C, 9, 16);
		t_tx(8'h88, 8'h81, 9, 64);
		// Rate double halves the mode 2 bit; a divisor of 1 doubles the variable bit
		wreg(SPC_PCTRL_ADDR, 8'h80);
		t_tx(8'h80, 8'h6B, 9, 32);
		wreg(SPC_PCTRL_ADDR, 8'h00);
		wreg(SPC_BAUD_ADDR, 8'h01);
		t_tx(8'h40, 8'h5A, 8, 32);
		wreg(SPC_BAUD_ADDR, 8'h00);
		t_rx(8'h50, 9'h03C, 8, 1'b1, 8'h55);
		t_rx(8'h70, 9'h0C3, 8, 1'b0, 8'h70);
		t_rx(8'hF0, 9'h05A, 9, 1'b1, 8'hF0);
		t_rx(8'hF0, 9'h1A6, 9, 1'b1, 8'hF5);
		t_rx(8'hD0, 9'h011, 9, 1'b1, 8'hD1);
		t_rx(8'h40, 9'h099, 8, 1'b1, 8'h40);
		t_fe();
		t_m0(8'h00, 6, 8'hB1);
		t_m0(8'h20, 2, 8'h4E);
		t_m0rx(8'hC6);
		rbuf_exp = 8'hC6;
		end_of_test();
	end
endmodule
